// ---- shared/pbm_pkg.sv ----
/*
  pbm_pkg: register map, field layouts, reset values and carrier types for
  the second-PLL and master clock select block.
  Assumes one 32-bit AHB-Lite slave port and word-aligned registers.
*/
package pbm_pkg;

  // register byte offsets
  localparam logic [7:0] PBM_OFS_OSC_CFG = 8'h20;
  localparam logic [7:0] PBM_OFS_PLLB_CFG = 8'h2C;
  localparam logic [7:0] PBM_OFS_MCK_CFG = 8'h30;
  localparam logic [7:0] PBM_OFS_PCK0_CFG = 8'h40;
  localparam logic [7:0] PBM_OFS_PCK_STEP = 8'h04;
  localparam logic [7:0] PBM_OFS_IRQ_EN = 8'h60;
  localparam logic [7:0] PBM_OFS_IRQ_DIS = 8'h64;
  localparam logic [7:0] PBM_OFS_STATUS = 8'h68;
  localparam logic [7:0] PBM_OFS_IRQ_MASK = 8'h6C;

  // field positions
  localparam int PBM_OSC_ENABLE_BIT = 0;
  localparam int PBM_OSC_BYPASS_BIT = 1;
  localparam int PBM_OSC_COUNT_LSB = 8;
  localparam int PBM_REF_DIV_LSB = 0;
  localparam int PBM_LOCKWAIT_LSB = 8;
  localparam int PBM_FREQ_RANGE_LSB = 14;
  localparam int PBM_MULT_LSB = 16;
  localparam int PBM_USB_DIV_LSB = 28;
  localparam int PBM_SRC_SEL_LSB = 0;
  localparam int PBM_PRESCALE_LSB = 2;
  localparam int PBM_MASTER_DIV_LSB = 8;

  // status / mask bit positions
  localparam int PBM_ST_MAIN_OSC = 0;
  localparam int PBM_ST_FIRST_PLL = 1;
  localparam int PBM_ST_SECOND_PLL = 2;
  localparam int PBM_ST_MASTER = 3;
  localparam int PBM_ST_PROG0 = 8;
  localparam int PBM_ST_WIDTH = 12;
  localparam logic [11:0] PBM_ST_IMPL = 12'h0_F0F;

  // counts
  localparam int PBM_NUM_PROG = 4;
  localparam logic [2:0] PBM_OSC_SLOW_MULT_SHIFT = 3'h3; // times eight
  localparam logic [1:0] PBM_READY_EDGES = 2'h2;

  // reset values
  localparam logic [31:0] PBM_RST_ZERO = 32'h0000_0000;
  localparam logic [11:0] PBM_RST_IRQ_EN = 12'h0_00;

  // source selector codes
  typedef enum logic [1:0] {
    PBM_SRC_SLOW = 2'b00,
    PBM_SRC_MAIN = 2'b01,
    PBM_SRC_FIRST_PLL = 2'b10,
    PBM_SRC_SECOND_PLL = 2'b11
  } pbm_src_t;

  // second PLL configuration
  typedef struct packed {
    logic [1:0] usb_clock_divider;
    logic [10:0] second_pll_multiplier;
    logic [1:0] second_pll_freq_range;
    logic [5:0] second_pll_lock_wait;
    logic [7:0] second_pll_input_divider;
  } pbm_pllb_t;

  // master or programmable clock selection
  typedef struct packed {
    logic [1:0] master_division;
    logic [2:0] source_divider_code;
    pbm_src_t clock_source_select;
  } pbm_clk_sel_t;

  // main oscillator control
  typedef struct packed {
    logic [7:0] main_osc_startup_count;
    logic main_osc_bypass;
    logic main_osc_enable;
  } pbm_osc_t;

endpackage

// ---- rtl/pbm_clk_div.sv ----
/*
  pbm_clk_div: divides a sampled clock level by two to the power of a shift.
  Assumes the source is synchronous to i_clock and well below half its rate.
*/
`timescale 1ns/100ps
`default_nettype none

module pbm_clk_div
  import pbm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_src,
  input wire logic [3:0] i_shift,
  output logic o_clk,
  output logic o_rise
);

  logic src_prev_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  assign cnt_next = cnt_reg + 8'h01;

  // source edge history
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= i_src;
    end
  end

  // ripple count of source rises; output taps one bit of it
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_reg <= 8'h00;
      o_clk <= 1'b0;
    end else if (i_shift == 4'h0) begin
      o_clk <= i_src; // divide by one: pass through, one cycle late
    end else if (i_src && !src_prev_reg) begin
      cnt_reg <= cnt_next;
      o_clk <= cnt_next[i_shift[2:0] - 3'h1];
    end
  end

  // one-cycle pulse on each output rise
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rise <= 1'b0;
    end else begin
      o_rise <= (i_shift == 4'h0) ? (i_src && !o_clk) :
                (i_src && !src_prev_reg && cnt_next[i_shift[2:0] - 3'h1] && !o_clk);
    end
  end

endmodule

`default_nettype wire

// ---- rtl/pbm_clock_ctrl.sv ----
/*
  pbm_clock_ctrl: second PLL control, USB divider, master and processor
  clock selection, four programmable clocks, readiness status and masks.
  Assumes all clock inputs are sampled levels synchronous to i_clock and
  slower than half its rate; the second PLL analog core takes the
  reference, multiplier and enable driven here and returns its clock.
*/
//
// Behaviour
// [RULE1] input divider: 0 off, 1 bypass, N divides
// [RULE2] lock flag after programmed slow cycles
// [RULE3] multiplier zero switches second PLL off
// [RULE4] multiplier code plus one drives PLL
// [RULE5] USB divider: 1, 2, 4; 11 reserved
// [RULE6] master source: slow, main, PLL1, PLL2
// [RULE7] processor prescaler divides by two-power code
// [RULE8] master division: 1, 2, 4 of processor
// [RULE9] each programmable clock selects its source
// [RULE10] each programmable clock has own prescaler
// [RULE11] enable register writes ones to enable
// [RULE12] disable register writes ones to disable
// [RULE13] mask reads zero enabled, one disabled
// [RULE14] status shows main oscillator stabilized
// [RULE15] status shows first PLL lock
// [RULE16] status shows second PLL lock
// [RULE17] status shows master clock ready
// [RULE18] status shows four programmable clock readies
// [RULE19] oscillator wait is count times eight
// [RULE20] bypass sets oscillator stable at once
// [RULE21] interrupt while enabled status flag set
// [RULE22] master change clears ready until stable
// [RULE23] software avoids reserved encodings
`timescale 1ns/100ps
`default_nettype none

module pbm_clock_ctrl
  import pbm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_slow_clock,
  input wire logic i_main_clock,
  input wire logic i_first_pll_clock,
  input wire logic i_first_pll_locked,
  input wire logic i_second_pll_clock,
  output logic o_main_osc_enable,
  output logic o_main_osc_bypass,
  output logic o_pllb_ref_clock,
  output logic o_pllb_enable,
  output logic [10:0] o_pllb_multiplier,
  output logic [1:0] o_pllb_freq_range,
  output logic o_usb_clock,
  output logic o_proc_clock,
  output logic o_master_clock,
  output logic [3:0] o_prog_clock,
  output logic o_irq
);

  // pick one of the four sources by the shared selector encoding
  function automatic logic pick_source(input pbm_src_t sel, input logic slow,
                                       input logic main, input logic pll1, input logic pll2);
    case (sel)
      PBM_SRC_SLOW: pick_source = slow;
      PBM_SRC_MAIN: pick_source = main;
      PBM_SRC_FIRST_PLL: pick_source = pll1;
      PBM_SRC_SECOND_PLL: pick_source = pll2;
      default: pick_source = 1'b0;
    endcase
  endfunction

  // match a word address against a register offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // bus state
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic addr_phase;
  logic wr_now;

  // configuration
  pbm_osc_t osc_reg;
  pbm_pllb_t pllb_reg;
  pbm_clk_sel_t mck_reg;
  pbm_clk_sel_t pck_reg [PBM_NUM_PROG];
  logic [11:0] irq_en_reg;

  // status state
  logic main_stable_reg;
  logic [10:0] osc_cnt_reg;
  logic pllb_locked_reg;
  logic [5:0] lock_cnt_reg;
  logic mck_ready_reg;
  logic [1:0] mck_edges_reg;
  logic [3:0] pck_ready_reg;
  logic [1:0] pck_edges_reg [PBM_NUM_PROG];
  logic [11:0] status;

  // clock edges and dividers
  logic slow_prev_reg;
  logic main_prev_reg;
  logic slow_rise;
  logic main_rise;
  logic [7:0] second_pll_input_divider_cnt_reg;
  logic mck_src;
  logic proc_rise;
  logic mck_rise;
  logic [3:0] pck_rise;
  logic [3:0] pck_src;

  assign addr_phase = i_hsel && i_htrans[1] && i_hready;
  assign wr_now = wr_pend_reg;
  assign slow_rise = i_slow_clock && !slow_prev_reg;
  assign main_rise = i_main_clock && !main_prev_reg;

  // AHB-Lite address phase capture; reads take one wait state so that
  // a read right after a write sees the written value
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      o_hreadyout <= 1'b1;
    end else begin
      wr_pend_reg <= addr_phase && i_hwrite;
      if (addr_phase) begin
        addr_reg <= i_haddr[7:0];
      end
      rd_pend_reg <= addr_phase && !i_hwrite;
      o_hreadyout <= !(addr_phase && !i_hwrite);
    end
  end

  // response is always OKAY
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_hresp <= 1'b0;
    end else begin
      o_hresp <= 1'b0;
    end
  end

  // read data; unmapped and write-only offsets read as zero
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_hrdata <= PBM_RST_ZERO;
    end else if (rd_pend_reg) begin
      o_hrdata <= PBM_RST_ZERO;
      if (hit(addr_reg, PBM_OFS_OSC_CFG)) begin
        o_hrdata[15:0] <= {osc_reg.main_osc_startup_count, 6'h00,
                           osc_reg.main_osc_bypass, osc_reg.main_osc_enable};
      end
      if (hit(addr_reg, PBM_OFS_PLLB_CFG)) begin
        o_hrdata[29:28] <= pllb_reg.usb_clock_divider;
        o_hrdata[26:16] <= pllb_reg.second_pll_multiplier;
        o_hrdata[15:0] <= pllb_reg[15:0];
      end
      if (hit(addr_reg, PBM_OFS_MCK_CFG)) begin
        o_hrdata[9:0] <= {mck_reg.master_division, 3'h0, mck_reg.source_divider_code,
                          mck_reg.clock_source_select};
      end
      for (int k = 0; k < PBM_NUM_PROG; k++) begin
        if (hit(addr_reg, PBM_OFS_PCK0_CFG + 8'(k * 4))) begin
          o_hrdata[4:0] <= {pck_reg[k].source_divider_code, pck_reg[k].clock_source_select};
        end
      end
      if (hit(addr_reg, PBM_OFS_STATUS)) begin
        o_hrdata[11:0] <= status; // [RULE14] [RULE15] [RULE16] [RULE17] [RULE18]
      end
      if (hit(addr_reg, PBM_OFS_IRQ_MASK)) begin
        o_hrdata[11:0] <= ~irq_en_reg & PBM_ST_IMPL; // [RULE13]
      end
    end
  end

  // configuration writes land at the end of the data phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      osc_reg <= '0;
      pllb_reg <= '0;
      mck_reg <= '0;
      for (int k = 0; k < PBM_NUM_PROG; k++) begin
        pck_reg[k] <= '0;
      end
    end else if (wr_now) begin
      if (hit(addr_reg, PBM_OFS_OSC_CFG)) begin
        osc_reg <= {i_hwdata[15:8], i_hwdata[1], i_hwdata[0]};
      end
      if (hit(addr_reg, PBM_OFS_PLLB_CFG)) begin
        pllb_reg <= {i_hwdata[29:28], i_hwdata[26:16], i_hwdata[15:0]};
      end
      if (hit(addr_reg, PBM_OFS_MCK_CFG)) begin
        mck_reg <= {i_hwdata[9:8], i_hwdata[4:0]};
      end
      for (int k = 0; k < PBM_NUM_PROG; k++) begin
        if (hit(addr_reg, PBM_OFS_PCK0_CFG + 8'(k * 4))) begin
          pck_reg[k] <= {2'b00, i_hwdata[4:0]};
        end
      end
    end
  end

  // interrupt enable bits, set by enable writes, cleared by disable writes
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      irq_en_reg <= PBM_RST_IRQ_EN;
    end else if (wr_now && hit(addr_reg, PBM_OFS_IRQ_EN)) begin
      irq_en_reg <= irq_en_reg | (i_hwdata[11:0] & PBM_ST_IMPL); // [RULE11]
    end else if (wr_now && hit(addr_reg, PBM_OFS_IRQ_DIS)) begin
      irq_en_reg <= irq_en_reg & ~i_hwdata[11:0]; // [RULE12]
    end
  end

  // source edge history for slow and main clocks
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      slow_prev_reg <= 1'b0;
      main_prev_reg <= 1'b0;
    end else begin
      slow_prev_reg <= i_slow_clock;
      main_prev_reg <= i_main_clock;
    end
  end

  // main oscillator start-up wait, counted in slow clock rises
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      main_stable_reg <= 1'b0;
      osc_cnt_reg <= 11'h000;
    end else if (wr_now && hit(addr_reg, PBM_OFS_OSC_CFG)) begin
      main_stable_reg <= i_hwdata[PBM_OSC_BYPASS_BIT]; // [RULE20]
      osc_cnt_reg <= {3'h0, i_hwdata[15:8]} << PBM_OSC_SLOW_MULT_SHIFT; // [RULE19]
    end else if (osc_reg.main_osc_bypass) begin
      main_stable_reg <= 1'b1; // [RULE20]
    end else if (osc_reg.main_osc_enable && !main_stable_reg) begin
      if (osc_cnt_reg == 11'h000) begin
        main_stable_reg <= 1'b1; // [RULE14] [RULE19]
      end else if (slow_rise) begin
        osc_cnt_reg <= osc_cnt_reg - 11'h001;
      end
    end
  end

  // second PLL lock wait restarts on every write to its register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pllb_locked_reg <= 1'b0;
      lock_cnt_reg <= 6'h00;
    end else if (wr_now && hit(addr_reg, PBM_OFS_PLLB_CFG)) begin
      pllb_locked_reg <= 1'b0;
      lock_cnt_reg <= i_hwdata[13:8]; // [RULE2]
    end else if (pllb_reg.second_pll_multiplier == 11'h000) begin
      pllb_locked_reg <= 1'b0; // [RULE3] switched off never locks
    end else if (!pllb_locked_reg) begin
      if (lock_cnt_reg == 6'h00) begin
        pllb_locked_reg <= 1'b1; // [RULE2] [RULE16]
      end else if (slow_rise) begin
        lock_cnt_reg <= lock_cnt_reg - 6'h01;
      end
    end
  end

  // input divider of the second PLL, counted on main clock rises
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      second_pll_input_divider_cnt_reg <= 8'h00;
      o_pllb_ref_clock <= 1'b0;
    end else begin
      case (pllb_reg.second_pll_input_divider)
        8'h00: o_pllb_ref_clock <= 1'b0; // [RULE1]
        8'h01: o_pllb_ref_clock <= i_main_clock; // [RULE1]
        default: begin
          if (main_rise) begin
            second_pll_input_divider_cnt_reg <= (second_pll_input_divider_cnt_reg >= pllb_reg.second_pll_input_divider - 8'h01) ?
                            8'h00 : second_pll_input_divider_cnt_reg + 8'h01;
          end
          o_pllb_ref_clock <= (second_pll_input_divider_cnt_reg < (pllb_reg.second_pll_input_divider >> 1)); // [RULE1]
        end
      endcase
    end
  end

  // controls to the second PLL analog core and main oscillator
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pllb_enable <= 1'b0;
      o_pllb_multiplier <= 11'h000;
      o_pllb_freq_range <= 2'h0;
      o_main_osc_enable <= 1'b0;
      o_main_osc_bypass <= 1'b0;
    end else begin
      o_pllb_enable <= (pllb_reg.second_pll_multiplier != 11'h000); // [RULE3]
      o_pllb_multiplier <= pllb_reg.second_pll_multiplier; // [RULE4] core runs at ref times this plus one
      o_pllb_freq_range <= pllb_reg.second_pll_freq_range;
      o_main_osc_enable <= osc_reg.main_osc_enable;
      o_main_osc_bypass <= osc_reg.main_osc_bypass;
    end
  end

  // USB clock from the second PLL output; code 11 divides by eight
  pbm_clk_div u_usb_div (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_src(i_second_pll_clock),
    .i_shift({2'b00, pllb_reg.usb_clock_divider}), // [RULE5] [RULE23]
    .o_clk(o_usb_clock),
    .o_rise()
  );

  // master path: source select, processor prescaler, master division
  assign mck_src = pick_source(mck_reg.clock_source_select, i_slow_clock, i_main_clock,
                               i_first_pll_clock, i_second_pll_clock); // [RULE6]

  pbm_clk_div u_proc_div (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_src(mck_src),
    .i_shift({1'b0, mck_reg.source_divider_code}), // [RULE7]
    .o_clk(o_proc_clock),
    .o_rise(proc_rise)
  );

  pbm_clk_div u_mck_div (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_src(o_proc_clock),
    .i_shift({2'b00, mck_reg.master_division}), // [RULE8]
    .o_clk(o_master_clock),
    .o_rise(mck_rise)
  );

  // master ready drops on a new setting and returns after two clean edges
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mck_ready_reg <= 1'b0;
      mck_edges_reg <= 2'h0;
    end else if (wr_now && hit(addr_reg, PBM_OFS_MCK_CFG)) begin
      mck_ready_reg <= 1'b0; // [RULE22]
      mck_edges_reg <= 2'h0;
    end else if (mck_rise && !mck_ready_reg) begin
      mck_edges_reg <= mck_edges_reg + 2'h1;
      mck_ready_reg <= (mck_edges_reg + 2'h1 == PBM_READY_EDGES); // [RULE17] [RULE22]
    end
  end

  // programmable clocks, each with own selector, prescaler and ready flag
  for (genvar g = 0; g < PBM_NUM_PROG; g++) begin : g_prog
    assign pck_src[g] = pick_source(pck_reg[g].clock_source_select, i_slow_clock, i_main_clock,
                                    i_first_pll_clock, i_second_pll_clock); // [RULE9]

    pbm_clk_div u_pck_div (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_src(pck_src[g]),
      .i_shift({1'b0, pck_reg[g].source_divider_code}), // [RULE10]
      .o_clk(o_prog_clock[g]),
      .o_rise(pck_rise[g])
    );

    // same settle rule as the master clock
    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        pck_ready_reg[g] <= 1'b0;
        pck_edges_reg[g] <= 2'h0;
      end else if (wr_now && hit(addr_reg, PBM_OFS_PCK0_CFG + 8'(g * 4))) begin
        pck_ready_reg[g] <= 1'b0;
        pck_edges_reg[g] <= 2'h0;
      end else if (pck_rise[g] && !pck_ready_reg[g]) begin
        pck_edges_reg[g] <= pck_edges_reg[g] + 2'h1;
        pck_ready_reg[g] <= (pck_edges_reg[g] + 2'h1 == PBM_READY_EDGES); // [RULE18]
      end
    end
  end

  // live status word
  assign status = {pck_ready_reg, 4'h0, mck_ready_reg, pllb_locked_reg,
                   i_first_pll_locked, main_stable_reg}; // [RULE15]

  // single level interrupt; follows status, not sticky
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & irq_en_reg); // [RULE21]
    end
  end

endmodule

`default_nettype wire

// ---- test/pbm_clock_ctrl_properties.sv ----
/*
  pbm_clock_ctrl_properties: concurrent checks on the clock control ports.
  Assumes one AHB-Lite master, one clock domain and whole-word writes.
*/
`timescale 1ns/100ps
`default_nettype none

module pbm_clock_ctrl_properties
  import pbm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_main_osc_bypass,
  input wire logic o_pllb_ref_clock,
  input wire logic o_pllb_enable,
  input wire logic [10:0] o_pllb_multiplier,
  input wire logic o_irq
);
  logic ap_wr;
  logic [7:0] ap_adr;
  logic [7:0] sh_div;
  logic [10:0] sh_mul;
  logic sh_byp;
  logic [11:0] sh_en;
  logic go;
  logic wr_pllb;
  logic wr_osc;
  // taken requests and the data phase of a write
  assign go = i_hsel && i_htrans[1] && i_hready;
  assign wr_pllb = ap_wr && i_hready && (ap_adr == PBM_OFS_PLLB_CFG);
  assign wr_osc = ap_wr && i_hready && (ap_adr == PBM_OFS_OSC_CFG);

  // address phase memory, so the data phase knows its target
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ap_wr <= 1'b0;
      ap_adr <= 8'h00;
    end else if (i_hready) begin
      ap_wr <= go && i_hwrite;
      ap_adr <= i_haddr[7:0];
    end
  end

  // shadow of the fields the checks need; writes land at the data edge
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sh_div <= 8'h00;
      sh_mul <= 11'h000;
      sh_byp <= 1'b0;
      sh_en <= 12'h000;
    end else if (ap_wr && i_hready) begin
      case (ap_adr)
        PBM_OFS_PLLB_CFG: begin
          sh_div <= i_hwdata[7:0];
          sh_mul <= i_hwdata[26:16];
        end
        PBM_OFS_OSC_CFG: sh_byp <= i_hwdata[1];
        PBM_OFS_IRQ_EN: sh_en <= sh_en | (i_hwdata[11:0] & PBM_ST_IMPL);
        PBM_OFS_IRQ_DIS: sh_en <= sh_en & ~i_hwdata[11:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  chk_resp_okay: assert property (o_hresp == 1'b0)
    else $error("slave response not okay");
  chk_read_wait: assert property (go && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read did not take exactly one wait cycle");
  chk_write_nowait: assert property (go && i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  chk_rdata_hold: assert property (o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
    else $error("read data changed outside a read");
  chk_pll_off: assert property (
    wr_pllb |=> ##1 (o_pllb_enable == (sh_mul != 11'h000)))
    else $error("second pll enable does not follow multiplier");
  chk_mul_copy: assert property (
    wr_pllb |=> ##[0:1] (o_pllb_multiplier == sh_mul))
    else $error("multiplier output differs from written field");
  chk_ref_zero: assert property ((sh_div == 8'h00) [*4] |-> !o_pllb_ref_clock)
    else $error("reference clock runs with divider code zero");
  chk_irq_gate: assert property ((sh_en == 12'h000) [*3] |-> !o_irq)
    else $error("interrupt raised with nothing enabled");
  chk_bypass_copy: assert property (
    wr_osc |=> ##[0:1] (o_main_osc_bypass == sh_byp))
    else $error("bypass output differs from written bit");
endmodule

bind pbm_clock_ctrl pbm_clock_ctrl_properties u_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_hrdata(o_hrdata), .o_main_osc_bypass(o_main_osc_bypass), .o_pllb_ref_clock(o_pllb_ref_clock),
  .o_pllb_enable(o_pllb_enable), .o_pllb_multiplier(o_pllb_multiplier), .o_irq(o_irq));

`default_nettype wire

// ---- test/tb_top.sv ----
/*
  tb_top: directed bench for pbm_clock_ctrl over its AHB-Lite port.
  Assumes source clocks made here from a cycle counter, well below half rate.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import pbm_pkg::*;
;
  localparam int WIN = 240;
  logic clk;
  logic rst_n;
  logic hsel;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic hwrite;
  logic [31:0] hwdata;
  logic [7:0] cyc = 8'h00;
  logic locked;
  logic hrdy;
  logic [31:0] hrdata;
  logic ref_c, usb_c, proc_c, mck_c, irq, byp, pen, oen;
  logic [3:0] pck;
  logic [10:0] pmul;
  int error_cnt;
  int check_count;
  int rise [6];
  wire logic [5:0] mon = {ref_c, usb_c, proc_c, mck_c, pck[0], cyc[1]};

  // sources: slow period 8, main and second pll 4, first pll 16
  pbm_clock_ctrl dut (.i_clock(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(), .o_hrdata(hrdata), .i_slow_clock(cyc[2]),
    .i_main_clock(cyc[1]), .i_first_pll_clock(cyc[3]), .i_first_pll_locked(locked),
    .i_second_pll_clock(cyc[1]), .o_main_osc_enable(oen), .o_main_osc_bypass(byp),
    .o_pllb_ref_clock(ref_c), .o_pllb_enable(pen), .o_pllb_multiplier(pmul),
    .o_pllb_freq_range(), .o_usb_clock(usb_c), .o_proc_clock(proc_c), .o_master_clock(mck_c),
    .o_prog_clock(pck), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // free-running counter behind all source clocks
  always @(posedge clk) cyc <= cyc + 8'h01;

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bounded wait for hready sampled high
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      $display("MISMATCH hreadyout exp 1 got %b", hrdy);
      error_cnt++;
      test_done();
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // rise counts may be off by one at the window edges
  task automatic near(input string nm, input int e, input int g);
    check_count++;
    if (g < e - 1 || g > e + 1) begin
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0000_0000, q);
    chk(nm, e, q & m);
  endtask
  task automatic meas();
    logic [5:0] p;
    p = mon;
    rise = '{default: 0};
    repeat (WIN) begin
      @(posedge clk);
      for (int k = 0; k < 6; k++) begin
        if (mon[k] && !p[k]) rise[k]++;
      end
      p = mon;
    end
  endtask

  // reset values, zero reads of unmapped and write-only offsets, first lock flag and read-write readback
  task automatic t_regs();
    rd(PBM_OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F0F, "mask");
    rd(8'h7C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    rd(PBM_OFS_IRQ_EN, 32'hFFFF_FFFF, 32'h0000_0000, "enable read");
    rd(PBM_OFS_STATUS, 32'h0000_0002, 32'h0000_0000, "first lock");
    locked <= 1'b1;
    rd(PBM_OFS_STATUS, 32'h0000_0002, 32'h0000_0002, "first lock");
    wr(PBM_OFS_PCK0_CFG + PBM_OFS_PCK_STEP, 32'h0000_001B);
    rd(PBM_OFS_PCK0_CFG + PBM_OFS_PCK_STEP, 32'h0000_001F, 32'h0000_001B, "prog1 cfg");
  endtask
  // enable and disable take ones only; irq follows enabled flags
  task automatic t_irq();
    wr(PBM_OFS_IRQ_EN, 32'h0000_0002);
    rd(PBM_OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F0D, "mask");
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(PBM_OFS_IRQ_EN, 32'h0000_0000);
    rd(PBM_OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F0D, "mask");
    wr(PBM_OFS_IRQ_DIS, 32'h0000_0000);
    rd(PBM_OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F0D, "mask");
    wr(PBM_OFS_IRQ_DIS, 32'h0000_0002);
    rd(PBM_OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F0F, "mask");
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0000, 32'(irq));
  endtask
  // bypass is immediate; start-up count of 2 waits 16 slow rises
  task automatic t_osc();
    wr(PBM_OFS_OSC_CFG, 32'h0000_0002);
    rd(PBM_OFS_STATUS, 32'h0000_0001, 32'h0000_0001, "osc bypass");
    chk("bypass pin", 32'h0000_0001, 32'(byp));
    wr(PBM_OFS_OSC_CFG, 32'h0000_0000);
    wr(PBM_OFS_OSC_CFG, 32'h0000_0201);
    repeat (80) @(posedge clk);
    rd(PBM_OFS_STATUS, 32'h0000_0001, 32'h0000_0000, "osc early");
    chk("enable pin", 32'h0000_0001, 32'(oen));
    repeat (80) @(posedge clk);
    rd(PBM_OFS_STATUS, 32'h0000_0001, 32'h0000_0001, "osc stable");
  endtask
  // divider, selector and prescaler codes measured by rise counts
  task automatic t_clk();
    wr(PBM_OFS_PLLB_CFG, 32'h1001_0302);
    repeat (2) @(posedge clk);
    chk("pll enable", 32'h0000_0001, 32'(pen));
    chk("multiplier", 32'h0000_0001, 32'(pmul));
    wr(PBM_OFS_MCK_CFG, 32'h0000_0105);
    rd(PBM_OFS_STATUS, 32'h0000_000C, 32'h0000_0000, "fresh ready");
    wr(PBM_OFS_PCK0_CFG, 32'h0000_0009);
    repeat (64) @(posedge clk);
    rd(PBM_OFS_STATUS, 32'h0000_010C, 32'h0000_010C, "ready flags");
    meas();
    near("main", WIN / 4, rise[0]);
    near("pll ref", WIN / 8, rise[5]);
    near("usb", WIN / 8, rise[4]);
    near("proc", WIN / 8, rise[3]);
    near("master", WIN / 16, rise[2]);
    near("prog0", WIN / 16, rise[1]);
    wr(PBM_OFS_PLLB_CFG, 32'h0000_0000);
    wr(PBM_OFS_MCK_CFG, 32'h0000_0000);
    wr(PBM_OFS_PCK0_CFG, 32'h0000_0002);
    repeat (40) @(posedge clk);
    chk("pll enable", 32'h0000_0000, 32'(pen));
    meas();
    near("pll ref", 0, rise[5]);
    near("usb", WIN / 4, rise[4]);
    near("proc", WIN / 8, rise[3]);
    near("master", WIN / 8, rise[2]);
    near("prog0", WIN / 16, rise[1]);
    wr(PBM_OFS_PLLB_CFG, 32'h2000_0000);
    wr(PBM_OFS_MCK_CFG, 32'h0000_020B);
    repeat (80) @(posedge clk);
    meas();
    near("usb", WIN / 16, rise[4]);
    near("proc", WIN / 16, rise[3]);
    near("master", WIN / 64, rise[2]);
  endtask

  // reset for five cycles, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    locked = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_irq();
    t_osc();
    t_clk();
    test_done();
  end
endmodule

`default_nettype wire
